/* common/urx_defines.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef URX_DEFINES_SVH
`define URX_DEFINES_SVH

// Byte offsets of the word registers
`define URX_OFS_STATUS 5'h00
`define URX_OFS_CTRL1 5'h04
`define URX_OFS_CTRL2 5'h08
`define URX_OFS_DATA 5'h0c
`define URX_OFS_BAUD 5'h10

// Port status register bits
`define URX_ST_AVAIL 0
`define URX_ST_OVR 1
`define URX_ST_NOISE 2
`define URX_ST_FE 3
`define URX_ST_PE 4
`define URX_ST_RIDLE 5
`define URX_ST_TXE 6
`define URX_ST_TXI 7

// Control register one bits
`define URX_C1_W 5
`define URX_C1_EN 0
`define URX_C1_NINE 1
`define URX_C1_PAR 2
`define URX_C1_ODD 3
`define URX_C1_TWO 4
`define URX_C1_RX8 8

// Control register two bits
`define URX_C2_W 8
`define URX_C2_RECEIVER_ENABLE 0
`define URX_C2_RIE 1
`define URX_C2_TEIE 2
`define URX_C2_TIIE 3
`define URX_C2_ADDRESS_DETECT_ENABLE 4
`define URX_C2_WAKE 5
`define URX_C2_GIE 6
`define URX_C2_PIE 7

// Reset values
`define URX_RST_C1 5'h00
`define URX_RST_C2 8'h00
`define URX_RST_BAUD 8'h00

// Sixteen-times oversampling points inside one bit
`define URX_TICK_S0 4'h7
`define URX_TICK_S1 4'h8
`define URX_TICK_S2 4'h9
`define URX_TICK_LAST 4'hf
`define URX_LAST_BIT8 4'h7
`define URX_LAST_BIT9 4'h8

// Clock start-up interval after a wake-up
`define URX_CLK_MHZ 20
`define URX_STARTUP_NS 1000
`define URX_STARTUP_CYC ((`URX_STARTUP_NS * `URX_CLK_MHZ + 999) / 1000)

`endif

/* common/urx_pkg.sv */
// Types shared by the serial receive block
package urx_pkg;

  // Receiver states, Gray coded along the frame
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_start = 3'h1,
    st_data = 3'h3,
    st_par = 3'h2,
    st_stop = 3'h6,
    st_stop2 = 3'h7
  } urx_rx_st_t;

  // One received word with its error flags
  typedef struct packed {
    logic [8:0] data;
    logic fe;
    logic pe;
    logic nf;
  } urx_entry_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [4:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } urx_av_req_t;

  // Avalon-MM answer to the master
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } urx_av_rsp_t;

  // All state of the receive block
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [4:0] ctl1;
    logic [7:0] ctl2;
    logic [7:0] baud;
    logic [7:0] div_cnt;
    urx_rx_st_t rx_st;
    logic [3:0] tick_cnt;
    logic [3:0] bit_cnt;
    logic [1:0] smp;
    logic [8:0] shreg;
    logic noise;
    logic fe;
    logic pe;
    logic par_acc;
    logic rx_prev;
    logic rx_last;
    urx_entry_t [1:0] rbuf;
    logic rd_ptr;
    logic [1:0] count;
    logic ovr;
    logic stat_seen;
    logic wake_pend;
    logic waking;
    logic [7:0] start_cnt;
    logic run_prev;
    logic txe_prev;
    logic txi_prev;
    logic irq;
    logic wake;
  } urx_state_t;

endpackage : urx_pkg

/* logic/urx_top.sv */
// Serial port receiver with error flags, interrupt merge and wake-up
//
// Overview of operation
// - Two buffered words; third completing sets overrun
// - Overrun keeps buffer, drops word, may interrupt
// - Overrun clears on status then data read
// - Noise flag rides with word, no own interrupt
// - Noise flag clears by status then data read
// - Low stop bit sets framing flag per word
// - Wrong parity sets parity flag per word
// - Five sources merge into one low pulse
// - Own enables for transmit, shared receive enable
// - Status flags read-only, cleared by sequences only
// - Address detect: interrupt only if top bit set
// - No address detect: interrupt on every word
// - Stopped peripheral clock freezes reception
// - Power-down leaves all registers unchanged
// - Armed RX falling edge with clock off wakes
// - RX ignored during post-wake start-up interval
// - Wake interrupts only with global and port enable
// - Wake interrupt waits for start-up interval end
// - Three samples, majority vote, disagreement means noise
// - Sample sixteen times per bit, shift per bit
`timescale 1ns/1ps
`include "urx_defines.svh"

module urx_top #(
  parameter int STARTUP_CYC = `URX_STARTUP_CYC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Register bus
  input wire urx_pkg::urx_av_req_t avs_req_i,
  output urx_pkg::urx_av_rsp_t avs_rsp_o,
  // Serial line and clock status
  input wire logic rx_i,
  input wire logic pclk_run_i,
  // Transmitter conditions
  input wire logic tx_empty_i,
  input wire logic tx_idle_i,
  // Interrupt and wake request
  output logic irq_n_o,
  output logic wake_o
);

  localparam logic [7:0] START_LAST = 8'(STARTUP_CYC - 1);

  urx_pkg::urx_state_t s;
  urx_pkg::urx_state_t n;
  urx_pkg::urx_entry_t hd;
  urx_pkg::urx_entry_t entry;
  logic tick;
  logic done;
  logic push;
  logic pop;
  logic ovr_ev;
  logic rx_ev;
  logic txe_ev;
  logic txi_ev;
  logic wake_fire;
  logic irq_ev;
  logic ie;
  logic top;
  logic vote;
  logic nz;
  logic rd_ld;
  logic data_ld;
  logic stat_ld;
  logic wr_acc;
  logic rx_en;
  logic wake_arm;
  logic [3:0] last_bit;

  // Answer after one wait state; data from flip-flops
  assign avs_rsp_o.waitrequest = (avs_req_i.read | avs_req_i.write) & ~s.ack;
  assign avs_rsp_o.readdata = s.rdata;
  assign irq_n_o = ~s.irq;
  assign wake_o = s.wake;

  // Whole next-state function
  always_comb begin
    n = s;
    hd = (s.count != 2'h0) ? s.rbuf[s.rd_ptr] : '0;
    n.rx_last = rx_i;
    n.wake = 1'b0;
    rd_ld = avs_req_i.read & ~s.ack;
    wr_acc = avs_req_i.write & s.ack & avs_req_i.byteenable[0];
    stat_ld = rd_ld && avs_req_i.address == `URX_OFS_STATUS;
    data_ld = rd_ld && avs_req_i.address == `URX_OFS_DATA;
    n.ack = (avs_req_i.read | avs_req_i.write) & ~s.ack;
    rx_en = s.ctl1[`URX_C1_EN] & s.ctl2[`URX_C2_RECEIVER_ENABLE];
    last_bit = s.ctl1[`URX_C1_NINE] ? `URX_LAST_BIT9 : `URX_LAST_BIT8;
    tick = pclk_run_i && (s.div_cnt == s.baud);
    vote = 1'b0;
    nz = 1'b0;
    done = 1'b0;
    entry = '0;

    // Baud divider gives the 16x sampling tick; halts with the clock
    if (pclk_run_i) begin
      n.div_cnt = tick ? 8'h00 : s.div_cnt + 8'h01;
    end

    // Receive engine; frozen while the peripheral clock is off
    if (!rx_en || s.waking) begin
      n.rx_st = urx_pkg::st_idle;
      // Track the line while waking, so a low held over start-up is no edge
      n.rx_prev = s.waking ? rx_i : 1'b1;
    end else if (tick) begin
      n.rx_prev = rx_i;
      n.tick_cnt = s.tick_cnt + 4'h1;
      if (s.tick_cnt == `URX_TICK_S0) begin
        n.smp[0] = rx_i;
      end
      if (s.tick_cnt == `URX_TICK_S1) begin
        n.smp[1] = rx_i;
      end
      // Majority of three samples, any disagreement is noise
      vote = (s.smp[0] & s.smp[1]) | (s.smp[0] & rx_i) |
             (s.smp[1] & rx_i);
      nz = (s.tick_cnt == `URX_TICK_S2) &&
           !(s.smp[0] == s.smp[1] && s.smp[1] == rx_i);
      if (nz) begin
        n.noise = 1'b1;
      end
      unique case (s.rx_st)
        urx_pkg::st_idle: begin
          // Falling edge only, so a held break never restarts
          if (s.rx_prev && !rx_i) begin
            n.rx_st = urx_pkg::st_start;
            n.tick_cnt = 4'h0;
            n.bit_cnt = 4'h0;
            n.noise = 1'b0;
            n.fe = 1'b0;
            n.pe = 1'b0;
            n.par_acc = 1'b0;
          end
        end
        urx_pkg::st_start: begin
          if (s.tick_cnt == `URX_TICK_S2 && vote) begin
            n.rx_st = urx_pkg::st_idle;
          end else if (s.tick_cnt == `URX_TICK_LAST) begin
            n.rx_st = urx_pkg::st_data;
          end
        end
        urx_pkg::st_data: begin
          // One shift per bit, least significant first
          if (s.tick_cnt == `URX_TICK_S2) begin
            n.shreg = {vote, s.shreg[8:1]};
            n.par_acc = s.par_acc ^ vote;
          end
          if (s.tick_cnt == `URX_TICK_LAST) begin
            n.bit_cnt = s.bit_cnt + 4'h1;
            if (s.bit_cnt == last_bit) begin
              n.rx_st = s.ctl1[`URX_C1_PAR] ? urx_pkg::st_par
                                             : urx_pkg::st_stop;
            end
          end
        end
        urx_pkg::st_par: begin
          if (s.tick_cnt == `URX_TICK_S2) begin
            n.pe = (s.par_acc ^ vote) != s.ctl1[`URX_C1_ODD];
          end
          if (s.tick_cnt == `URX_TICK_LAST) begin
            n.rx_st = urx_pkg::st_stop;
          end
        end
        urx_pkg::st_stop: begin
          if (s.tick_cnt == `URX_TICK_S2) begin
            n.fe = !vote;
            if (!s.ctl1[`URX_C1_TWO]) begin
              done = 1'b1;
              n.rx_st = urx_pkg::st_idle;
            end
          end else if (s.tick_cnt == `URX_TICK_LAST) begin
            n.rx_st = urx_pkg::st_stop2;
          end
        end
        urx_pkg::st_stop2: begin
          // Both stop bits must read high
          if (s.tick_cnt == `URX_TICK_S2) begin
            n.fe = s.fe | !vote;
            done = 1'b1;
            n.rx_st = urx_pkg::st_idle;
          end
        end
        default: begin
          n.rx_st = urx_pkg::st_idle;
        end
      endcase
      entry.data = s.ctl1[`URX_C1_NINE] ? s.shreg : {1'b0, s.shreg[8:1]};
      entry.fe = n.fe;
      entry.pe = s.pe & s.ctl1[`URX_C1_PAR];
      entry.nf = s.noise | nz;
    end

    // Status access arms the clear; data read completes it
    pop = data_ld && s.stat_seen && (s.count != 2'h0);
    push = done && (s.count != 2'h2 || pop);
    ovr_ev = done && s.count == 2'h2 && !pop;
    if (push) begin
      n.rbuf[s.rd_ptr ^ s.count[0]] = entry;
    end
    if (pop) begin
      n.rd_ptr = ~s.rd_ptr;
    end
    n.count = s.count + {1'b0, push} - {1'b0, pop};
    if (stat_ld) begin
      n.stat_seen = 1'b1;
    end else if (data_ld) begin
      n.stat_seen = 1'b0;
    end
    // A new overrun in the clearing cycle wins
    if (ovr_ev) begin
      n.ovr = 1'b1;
    end else if (data_ld && s.stat_seen) begin
      n.ovr = 1'b0;
    end

    // Registers written by software; status is never writable
    if (wr_acc) begin
      unique case (avs_req_i.address)
        `URX_OFS_CTRL1: n.ctl1 = avs_req_i.writedata[`URX_C1_W-1:0];
        `URX_OFS_CTRL2: n.ctl2 = avs_req_i.writedata[`URX_C2_W-1:0];
        `URX_OFS_BAUD: n.baud = avs_req_i.writedata[7:0];
        default: n.ctl1 = s.ctl1;
      endcase
    end

    // Read data captured in the wait cycle; unmapped reads zero
    if (rd_ld) begin
      n.rdata = 32'h0;
      unique case (avs_req_i.address)
        `URX_OFS_STATUS: begin
          n.rdata[`URX_ST_AVAIL] = s.count != 2'h0;
          n.rdata[`URX_ST_OVR] = s.ovr;
          n.rdata[`URX_ST_NOISE] = hd.nf;
          n.rdata[`URX_ST_FE] = hd.fe;
          n.rdata[`URX_ST_PE] = hd.pe;
          n.rdata[`URX_ST_RIDLE] = s.rx_st == urx_pkg::st_idle;
          n.rdata[`URX_ST_TXE] = tx_empty_i;
          n.rdata[`URX_ST_TXI] = tx_idle_i;
        end
        `URX_OFS_CTRL1: begin
          n.rdata[`URX_C1_W-1:0] = s.ctl1;
          n.rdata[`URX_C1_RX8] = hd.data[8];
        end
        `URX_OFS_CTRL2: n.rdata[`URX_C2_W-1:0] = s.ctl2;
        `URX_OFS_DATA: n.rdata[7:0] = hd.data[7:0];
        `URX_OFS_BAUD: n.rdata[7:0] = s.baud;
        default: n.rdata = 32'h0;
      endcase
    end

    // Wake-up: armed falling edge while the clock is stopped
    wake_arm = s.ctl2[`URX_C2_WAKE] & rx_en & s.ctl2[`URX_C2_RIE] &
               !pclk_run_i;
    if (wake_arm && s.rx_last && !rx_i) begin
      n.wake = 1'b1;
      n.wake_pend = 1'b1;
    end
    n.run_prev = pclk_run_i;
    wake_fire = 1'b0;
    if (pclk_run_i && !s.run_prev && s.wake_pend && !s.waking) begin
      n.waking = 1'b1;
      n.start_cnt = 8'h00;
    end else if (s.waking) begin
      n.start_cnt = s.start_cnt + 8'h01;
      if (s.start_cnt == START_LAST) begin
        n.waking = 1'b0;
        n.wake_pend = 1'b0;
        wake_fire = 1'b1;
      end
    end

    // Merge of the five sources into one low pulse
    top = s.ctl1[`URX_C1_NINE] ? entry.data[8] : entry.data[7];
    rx_ev = push && (!s.ctl2[`URX_C2_ADDRESS_DETECT_ENABLE] || top);
    txe_ev = tx_empty_i & !s.txe_prev;
    txi_ev = tx_idle_i & !s.txi_prev;
    n.txe_prev = tx_empty_i;
    n.txi_prev = tx_idle_i;
    ie = s.ctl2[`URX_C2_GIE] & s.ctl2[`URX_C2_PIE];
    irq_ev = ie & ((s.ctl2[`URX_C2_RIE] & (rx_ev | ovr_ev)) |
                   (s.ctl2[`URX_C2_TEIE] & txe_ev) |
                   (s.ctl2[`URX_C2_TIIE] & txi_ev) |
                   wake_fire);
    n.irq = irq_ev & ~s.irq;
  end

  // State register; power modes never touch it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.ctl1 <= `URX_RST_C1;
      s.ctl2 <= `URX_RST_C2;
      s.baud <= `URX_RST_BAUD;
      s.rx_prev <= 1'b1;
      s.rx_last <= 1'b1;
      s.rx_st <= urx_pkg::st_idle;
    end else begin
      s <= n;
    end
  end

  // Checks on the logic above
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_full_done;
    done && s.count == 2'h2 && !pop;
  endsequence

  sequence s_ovr_irq;
    !irq_n_o ##1 irq_n_o;
  endsequence

  property p_ovr_set;
    s_full_done |=> s.ovr && s.count == 2'h2;
  endproperty
  a_ovr_set: assert property (p_ovr_set)
    else $error("overrun flag not set on third word");

  property p_ovr_keep;
    s_full_done ##0 (ie && s.ctl2[`URX_C2_RIE] && !s.irq)
      |=> $stable(s.rbuf) ##0 s_ovr_irq;
  endproperty
  a_ovr_keep: assert property (p_ovr_keep)
    else $error("overrun lost buffer or missed interrupt");

  property p_ovr_clear;
    $fell(s.ovr) |-> $past(data_ld && s.stat_seen);
  endproperty
  a_ovr_clear: assert property (p_ovr_clear)
    else $error("overrun cleared without status then data read");

  property p_nf_word;
    push && s.count == 2'h0 && entry.nf |=> hd.nf && s.count == 2'h1;
  endproperty
  a_nf_word: assert property (p_nf_word)
    else $error("noise flag not stored with word");

  property p_fe_word;
    push && s.count == 2'h0 |=> hd.fe == $past(entry.fe);
  endproperty
  a_fe_word: assert property (p_fe_word)
    else $error("framing flag not stored with word");

  property p_pe_off;
    push && !s.ctl1[`URX_C1_PAR] && s.count == 2'h0 |=> !hd.pe;
  endproperty
  a_pe_off: assert property (p_pe_off)
    else $error("parity flag set with parity disabled");

  property p_irq_pulse;
    !irq_n_o |=> irq_n_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt pulse longer than one cycle");

  property p_flag_ro;
    $rose(s.ovr) |-> $past(ovr_ev);
  endproperty
  a_flag_ro: assert property (p_flag_ro)
    else $error("overrun flag set without overrun");

  property p_addr;
    push && s.ctl2[`URX_C2_ADDRESS_DETECT_ENABLE] && !top && !ovr_ev && !txe_ev &&
      !txi_ev && !wake_fire |=> irq_n_o;
  endproperty
  a_addr: assert property (p_addr)
    else $error("data word interrupted under address detect");

  property p_freeze;
    !pclk_run_i |=> $stable(s.tick_cnt) && $stable(s.div_cnt);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("receiver advanced with clock stopped");

  property p_wake_late;
    wake_fire |-> s.waking && s.start_cnt == START_LAST;
  endproperty
  a_wake_late: assert property (p_wake_late)
    else $error("wake interrupt before start-up end");

endmodule : urx_top

/* test/urx_line_model.sv */
// Remote serial transmitter model that drives the receive line
`timescale 1ns/1ps

module urx_line_model (
  // Clock and port clock run status
  input wire logic mclk_i,
  input wire logic run_i,
  // Serial line
  output logic rx_o
);
  // Line rests high between frames, as the pull-up leaves it
  initial rx_o = 1'b1;

  // One bit of sixteen clocks; stalls while the port clock is stopped
  task automatic bit_out(input logic v, input logic g);
    for (int i = 0; i < 16; i++) begin
      rx_o <= (g && i == 9) ? ~v : v;
      do @(posedge mclk_i); while (run_i !== 1'b1);
    end
  endtask : bit_out

  // Whole frame, LSB first; faults only on request
  task automatic send(input logic [8:0] d, input logic nine, input logic pen,
      input logic odd, input logic pb, input logic two, input logic [1:0] lo,
      input logic g);
    logic p;
    p = ^(d & {nine, 8'hff}) ^ odd ^ pb;
    bit_out(1'b0, 1'b0);
    for (int i = 0; i < 9; i++) if (i < 8 || nine) bit_out(d[i], g && i == 0);
    if (pen) bit_out(p, 1'b0);
    bit_out(lo != 2'h1, 1'b0);
    if (two) bit_out(lo != 2'h2, 1'b0);
    bit_out(1'b1, 1'b0);
  endtask : send

  // Low pulse of len clocks, used to wake the port or to probe start-up
  task automatic fall(input int len);
    rx_o <= 1'b0;
    repeat (len) @(posedge mclk_i);
    rx_o <= 1'b1;
    @(posedge mclk_i);
  endtask : fall
endmodule : urx_line_model

/* test/urx_top_tb_top.sv */
// Self-checking bench for the serial receive block
`timescale 1ns/1ps
`include "urx_defines.svh"

module urx_top_tb_top;
  localparam int SUC = 4;
  localparam logic [4:0] a_st = `URX_OFS_STATUS;
  localparam logic [4:0] a_c1 = `URX_OFS_CTRL1;
  localparam logic [4:0] a_c2 = `URX_OFS_CTRL2;
  localparam logic [4:0] a_dt = `URX_OFS_DATA;
  localparam logic [4:0] a_bd = `URX_OFS_BAUD;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic pclk_run_i = 1'b1;
  logic tx_empty_i = 1'b0;
  logic tx_idle_i = 1'b0;
  logic rx_i;
  logic irq_n_o;
  logic wake_o;
  urx_pkg::urx_av_req_t req = '0;
  urx_pkg::urx_av_rsp_t rsp;
  logic [31:0] r;
  logic nine = 1'b0;
  logic pen = 1'b0;
  logic odd = 1'b0;
  logic two = 1'b0;
  int n_errors = 0;
  int samples_checked = 0;
  int n_irq = 0;
  int n_wake = 0;
  int ib = 0;

  // Clock of 50 ns period
  always #25 mclk_i = ~mclk_i;

  urx_top #(.STARTUP_CYC(SUC)) uut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_req_i(req), .avs_rsp_o(rsp),
    .rx_i(rx_i), .pclk_run_i(pclk_run_i), .tx_empty_i(tx_empty_i),
    .tx_idle_i(tx_idle_i), .irq_n_o(irq_n_o), .wake_o(wake_o)
  );

  urx_line_model far (.mclk_i(mclk_i), .run_i(pclk_run_i), .rx_o(rx_i));

  // Pulse counters; each pulse stands for one cycle only
  always @(posedge mclk_i) begin
    if (irq_n_o === 1'b0) n_irq <= n_irq + 1;
    if (wake_o === 1'b1) n_wake <= n_wake + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string m);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk

  // One bus access; request held until waitrequest is low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] d);
    req.read <= ~wr;
    req.write <= wr;
    req.address <= a;
    req.writedata <= d;
    req.byteenable <= 4'hf;
    do @(posedge mclk_i); while (rsp.waitrequest !== 1'b0);
    // Read data taken at the very edge that ends the wait
    r = rsp.readdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
    @(posedge mclk_i);
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h0);
    chk(r, e, m);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  // Status word: rx idle, tx levels and {pe, fe, nf, ovr, avail}
  function automatic logic [31:0] st(input logic [4:0] f);
    return {24'h0, tx_idle_i, tx_empty_i, 1'b1, f};
  endfunction : st

  // Status first, then data, which also pops the head word
  task automatic word(input logic [4:0] f, input logic [7:0] d);
    rd(a_st, st(f), "status");
    rd(a_dt, {24'h0, d}, "data");
  endtask : word

  task automatic fr(input logic [8:0] d, input logic [1:0] lo, input logic g,
      input logic pb);
    ib = n_irq;
    far.send(d, nine, pen, odd, pb, two, lo, g);
  endtask : fr

  task automatic irqs(input logic [31:0] e);
    chk(32'(n_irq - ib), e, "irq pulses");
    ib = n_irq;
  endtask : irqs

  task automatic fin(input string s);
    $display("test %s finished", s);
  endtask : fin

  task automatic test_done();
    $display("compared %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // Watchdog, well above the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge mclk_i);
    n_errors++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(a_c1, 32'h0, "ctrl1 reset");
    rd(a_c2, 32'h0, "ctrl2 reset");
    rd(a_bd, 32'h0, "baud reset");
    wr(a_st, 32'hff);
    rd(a_st, st(5'h00), "status write");
    rd(5'h14, 32'h0, "unmapped");
    wr(a_c1, 32'h1);
    wr(a_c2, 32'hc3);
    fr(9'h0a5, 2'h0, 1'b0, 1'b0);
    irqs(32'h1);
    word(5'h01, 8'ha5);
    rd(a_st, st(5'h00), "emptied");
    rd(a_dt, 32'h0, "empty data");
    fin("basic");
    fr(9'h011, 2'h0, 1'b0, 1'b0);
    irqs(32'h1);
    fr(9'h022, 2'h0, 1'b0, 1'b0);
    irqs(32'h1);
    fr(9'h033, 2'h0, 1'b0, 1'b0);
    irqs(32'h1);
    rd(a_dt, 32'h11, "no pop");
    word(5'h03, 8'h11);
    word(5'h01, 8'h22);
    rd(a_st, st(5'h00), "third dropped");
    fin("overrun");
    fr(9'h05a, 2'h0, 1'b1, 1'b0);
    irqs(32'h1);
    word(5'h05, 8'h5a);
    rd(a_st, st(5'h00), "noise cleared");
    fr(9'h0f0, 2'h1, 1'b0, 1'b0);
    word(5'h09, 8'hf0);
    two = 1'b1;
    wr(a_c1, 32'h11);
    fr(9'h00f, 2'h2, 1'b0, 1'b0);
    fr(9'h0c3, 2'h0, 1'b0, 1'b0);
    word(5'h09, 8'h0f);
    word(5'h01, 8'hc3);
    two = 1'b0;
    wr(a_c1, 32'h1);
    fin("framing");
    pen = 1'b1;
    for (int i = 0; i < 4; i++) begin
      odd = i[1];
      wr(a_c1, {28'h0, odd, 3'h5});
      fr(9'h037, 2'h0, 1'b0, i[0]);
      word({i[0], 4'h1}, 8'h37);
    end
    pen = 1'b0;
    fin("parity");
    wr(a_c2, 32'hd3);
    for (int i = 0; i < 4; i++) begin
      logic [8:0] d;
      nine = i[1];
      d = nine ? {~i[0], 8'h55} : {1'b0, ~i[0], 7'h2a};
      wr(a_c1, {30'h0, nine, 1'b1});
      fr(d, 2'h0, 1'b0, 1'b0);
      irqs({31'h0, ~i[0]});
      rd(a_c1, {23'h0, d[8], 6'h0, nine, 1'b1}, "ninth bit");
      word(5'h01, d[7:0]);
    end
    nine = 1'b0;
    wr(a_c1, 32'h1);
    fin("address");
    for (int i = 0; i < 3; i++) begin
      wr(a_c2, 32'hc0 | (32'h4 << i));
      ib = n_irq;
      tx_empty_i <= 1'b1;
      tx_idle_i <= 1'b1;
      repeat (6) @(posedge mclk_i);
      irqs({31'h0, i < 2});
      rd(a_st, st(5'h00), "tx levels");
      tx_empty_i <= 1'b0;
      tx_idle_i <= 1'b0;
      @(posedge mclk_i);
    end
    fin("transmit");
    wr(a_c2, 32'he3);
    ib = n_irq;
    pclk_run_i <= 1'b0;
    @(posedge mclk_i);
    far.fall(2);
    repeat (4) @(posedge mclk_i);
    chk(32'(n_wake), 32'h1, "wake pulse");
    rd(a_c2, 32'he3, "ctrl2 kept");
    rd(a_c1, 32'h1, "ctrl1 kept");
    rd(a_st, st(5'h00), "no wake flag");
    irqs(32'h0);
    pclk_run_i <= 1'b1;
    repeat (SUC - 2) @(posedge mclk_i);
    irqs(32'h0);
    repeat (SUC + 6) @(posedge mclk_i);
    irqs(32'h1);
    wr(a_c2, 32'h23);
    pclk_run_i <= 1'b0;
    @(posedge mclk_i);
    far.fall(2);
    repeat (4) @(posedge mclk_i);
    chk(32'(n_wake), 32'h2, "second wake");
    pclk_run_i <= 1'b1;
    @(posedge mclk_i);
    // Line pulled low inside start-up and held past it must start nothing
    far.fall(20);
    repeat (SUC + 8) @(posedge mclk_i);
    irqs(32'h0);
    rd(a_st, st(5'h00), "no stray word");
    fin("wake");
    wr(a_c2, 32'hc3);
    fork
      fr(9'h03c, 2'h0, 1'b0, 1'b0);
      begin
        repeat (60) @(posedge mclk_i);
        pclk_run_i <= 1'b0;
        repeat (100) @(posedge mclk_i);
        pclk_run_i <= 1'b1;
      end
    join
    irqs(32'h1);
    word(5'h01, 8'h3c);
    fin("freeze");
    test_done();
  end
endmodule : urx_top_tb_top
